// ===== logic/text_display_memory_scanner.sv
/*
 * Display memory, screen scanner, cursor and attribute shading, host
 * transfers (single write, single read, fill cursor..pointer) and a
 * two-entry output buffer carrying one 7-dot slice per cell and line.
 * Assumes: all inputs synchronous to clk; the glyph ROM has a single
 * register stage, so its byte for rom_addr stands from the first rising
 * edge after rom_addr changes, one edge before the cell is pushed;
 * command pulses are one cycle wide. Reads and writes always use
 * pointer_addr; a transfer at the cursor is left to the host, which
 * copies the cursor address into the pointer first.
 */
`timescale 1ns/1ps

// Summary of operation
// - Each memory byte is one cell; low seven bits form the code.
// - Bit 7 set shows the cell bright or reversed, per mode input.
// - Display memory covers addresses 000 to 7FF, eleven bits.
// - Frame starts at screen start, 080 after reset; cells fetched at rising addresses.
// - Scan address wraps from 7FF to 000 inside a screen.
// - Host may change screen start anytime; next frames use it.
// - Screen has 24 rows of 80 cells, 1920 cells per frame.
// - Cursor shows where cell address equals cursor address.
// - Fill stores write buffer from cursor through pointer inclusive.
// - Glyph byte address is code times sixteen plus line index.
// - Nine scan lines per row, one glyph byte per line, top first.
// - Glyph bytes nine to fifteen of a group are never fetched.
// - Glyph bit one lights a dot, zero leaves it dark.
// - Cell is 7 by 9 dots; glyph bit 0 is ignored.
// - Graphic codes need no special mode; stored codes show as is.
// - Done flag sets when a read or write transfer completes.
module text_display_memory_scanner (
    input wire logic clk, // 10 MHz system clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic [10:0] screen_start, // Top-left cell address
    input wire logic [10:0] cursor_addr, // Cursor cell address
    input wire logic [10:0] pointer_addr, // Pointer address for commands
    input wire logic [7:0] write_buffer, // Byte for write and fill
    input wire logic cmd_write, // Pulse: write buffer at pointer
    input wire logic cmd_read, // Pulse: read memory at pointer
    input wire logic cmd_fill, // Pulse: fill cursor through pointer
    input wire logic reverse_mode, // Attribute: 1 reverse, 0 bright
    input wire logic cursor_on, // Show the cursor block
    input wire logic [7:0] rom_data, // Glyph byte from ROM
    output logic [10:0] rom_addr, // Glyph byte address
    output logic [7:0] read_buffer, // Byte from the last read command
    output logic transfer_done_flag, // Last command has completed
    output logic busy, // A command is in progress
    output logic pix_valid, // Slice at the output is valid
    input wire logic pix_ready, // Receiver takes the slice
    output logic [6:0] pix_dots, // Seven dots, left dot in bit 6
    output logic pix_bright, // High intensity for this slice
    output logic pix_line_start, // First cell of a scan line
    output logic pix_frame_start // First slice of a frame
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] mem_q [0:text_scan_pkg::MEM_DEPTH-1];
    logic [7:0] cell_q;
    logic [7:0] host_rd_q;

    text_scan_pkg::scan_state_t scan_q;
    text_scan_pkg::xfer_state_t xfer_q;

    logic [6:0] col_q;
    logic [3:0] line_q;
    logic [4:0] row_q;
    logic [10:0] row_base_q;
    logic [10:0] scan_addr;
    logic cursor_hit_q;
    logic attr_q;
    logic sol_q;
    logic sof_q;
    logic cursor_match;

    logic [10:0] fill_addr_q;
    logic [10:0] fill_end_q;
    logic mem_we;
    logic [10:0] mem_wa;

    // Two-entry output buffer: entry 0 is the head seen at the ports
    logic [9:0] ent0_q;
    logic [9:0] ent1_q;
    logic v0_q;
    logic v1_q;
    logic [9:0] push_word;
    logic push;
    logic pop;
    logic room;
    logic [6:0] glyph_dots;
    logic invert_cell;
    logic bright_cell;

    ////////////////////////////////////////////////////////////////////////
    // Display memory

    // Eleven-bit sum wraps 7FF to 000 by itself
    assign scan_addr = row_base_q + {4'h0, col_q};

    // Compared on the wrapped address, so the cursor follows a scroll
    assign cursor_match = cursor_on && (scan_addr == cursor_addr);

    // Host write and fill share the single write port; a fill is only
    // entered from idle, so the two never collide
    always_comb begin
        mem_we = 1'b0;
        mem_wa = pointer_addr;
        if (xfer_q == text_scan_pkg::XFER_IDLE && cmd_write) begin
            mem_we = 1'b1;
        end else if (xfer_q == text_scan_pkg::XFER_FILL) begin
            mem_we = 1'b1;
            mem_wa = fill_addr_q;
        end
    end

    // No reset on the array; contents are undefined until written
    always_ff @(posedge clk) begin
        if (ce) begin
            if (mem_we) begin
                mem_q[mem_wa] <= write_buffer;
            end
            cell_q <= mem_q[scan_addr];
            host_rd_q <= mem_q[pointer_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cell pipeline

    // One cell takes four cycles: read memory, address the ROM, let the
    // ROM register the byte, push. The byte is never used in the cycle
    // its address is launched, which keeps the ROM path short.

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scan_q <= text_scan_pkg::SCAN_MEM;
        end else if (ce) begin
            case (scan_q)
                text_scan_pkg::SCAN_MEM: begin
                    scan_q <= text_scan_pkg::SCAN_ROM;
                end
                text_scan_pkg::SCAN_ROM: begin
                    scan_q <= text_scan_pkg::SCAN_WAIT;
                end
                text_scan_pkg::SCAN_WAIT: begin
                    scan_q <= text_scan_pkg::SCAN_EMIT;
                end
                text_scan_pkg::SCAN_EMIT: begin
                    if (room) begin
                        scan_q <= text_scan_pkg::SCAN_MEM;
                    end
                end
                default: begin
                    scan_q <= text_scan_pkg::SCAN_MEM;
                end
            endcase
        end
    end

    // Cursor and markers are sampled while the cell is being read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cursor_hit_q <= 1'b0;
            sol_q <= 1'b0;
            sof_q <= 1'b0;
        end else if (ce && scan_q == text_scan_pkg::SCAN_MEM) begin
            cursor_hit_q <= cursor_match;
            sol_q <= (col_q == text_scan_pkg::COL_RESET);
            sof_q <= (col_q == text_scan_pkg::COL_RESET)
                && (line_q == text_scan_pkg::LINE_RESET)
                && (row_q == text_scan_pkg::ROW_RESET);
        end
    end

    // Code only, attribute stripped; any stored code is looked up as is
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rom_addr <= 11'h000;
            attr_q <= 1'b0;
        end else if (ce && scan_q == text_scan_pkg::SCAN_ROM) begin
            rom_addr <= {cell_q[text_scan_pkg::CODE_W-1:0],
                line_q};
            attr_q <= cell_q[text_scan_pkg::ATTR_BIT];
        end
    end

    // Bit 0 of the glyph byte is dropped; ones are lit dots
    always_comb begin
        glyph_dots = rom_data[7:1];
        // Cursor and reverse attribute cancel where both apply
        invert_cell = cursor_hit_q ^ (attr_q && reverse_mode);
        bright_cell = attr_q && !reverse_mode;
        push_word = {sof_q, sol_q, bright_cell,
            glyph_dots ^ {7{invert_cell}}};
    end

    assign push = (scan_q == text_scan_pkg::SCAN_EMIT) && room;

    ////////////////////////////////////////////////////////////////////////
    // Scan counters

    // Line index never passes 8, so bytes 9..15 of a glyph stay unread
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            col_q <= text_scan_pkg::COL_RESET;
            line_q <= text_scan_pkg::LINE_RESET;
            row_q <= text_scan_pkg::ROW_RESET;
            row_base_q <= text_scan_pkg::START_RESET;
        end else if (ce && push) begin
            if (col_q != text_scan_pkg::LAST_COL) begin
                col_q <= col_q + 7'h01;
            end else begin
                col_q <= text_scan_pkg::COL_RESET;
                if (line_q != text_scan_pkg::LAST_LINE) begin
                    line_q <= line_q + 4'h1;
                end else begin
                    line_q <= text_scan_pkg::LINE_RESET;
                    if (row_q != text_scan_pkg::LAST_ROW) begin
                        row_q <= row_q + 5'h01;
                        row_base_q <= row_base_q
                            + text_scan_pkg::ROW_STEP;
                    end else begin
                        row_q <= text_scan_pkg::ROW_RESET;
                        row_base_q <= screen_start;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer

    // Space only while the second entry is free, so a stalled receiver
    // holds the pipeline in SCAN_EMIT and no slice is lost
    assign room = !v1_q;
    assign pop = v0_q && pix_ready;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ent0_q <= 10'h000;
            ent1_q <= 10'h000;
            v0_q <= 1'b0;
            v1_q <= 1'b0;
        end else if (ce) begin
            case ({push, pop})
                2'b10: begin
                    if (!v0_q) begin
                        ent0_q <= push_word;
                        v0_q <= 1'b1;
                    end else begin
                        ent1_q <= push_word;
                        v1_q <= 1'b1;
                    end
                end
                2'b01: begin
                    ent0_q <= ent1_q;
                    v0_q <= v1_q;
                    v1_q <= 1'b0;
                end
                2'b11: begin
                    ent0_q <= push_word;
                end
                default: begin
                    ent0_q <= ent0_q;
                end
            endcase
        end
    end

    assign pix_valid = v0_q;
    assign pix_dots = ent0_q[6:0];
    assign pix_bright = ent0_q[7];
    assign pix_line_start = ent0_q[8];
    assign pix_frame_start = ent0_q[9];

    ////////////////////////////////////////////////////////////////////////
    // Host transfers

    // Read result is held until the next read completes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_buffer <= 8'h00;
        end else if (ce && xfer_q == text_scan_pkg::XFER_LOAD) begin
            read_buffer <= host_rd_q;
        end
    end

    // Pulses that arrive while busy are dropped; the host polls done
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xfer_q <= text_scan_pkg::XFER_IDLE;
            fill_addr_q <= text_scan_pkg::MEM_FIRST;
            fill_end_q <= text_scan_pkg::MEM_FIRST;
            transfer_done_flag <= 1'b1;
            busy <= 1'b0;
        end else if (ce) begin
            case (xfer_q)
                text_scan_pkg::XFER_IDLE: begin
                    if (cmd_write) begin
                        transfer_done_flag <= 1'b1;
                    end else if (cmd_read) begin
                        xfer_q <= text_scan_pkg::XFER_READ;
                        transfer_done_flag <= 1'b0;
                        busy <= 1'b1;
                    end else if (cmd_fill) begin
                        xfer_q <= text_scan_pkg::XFER_FILL;
                        fill_addr_q <= cursor_addr;
                        fill_end_q <= pointer_addr;
                        transfer_done_flag <= 1'b0;
                        busy <= 1'b1;
                    end
                end
                text_scan_pkg::XFER_READ: begin
                    xfer_q <= text_scan_pkg::XFER_LOAD;
                end
                text_scan_pkg::XFER_LOAD: begin
                    transfer_done_flag <= 1'b1;
                    busy <= 1'b0;
                    xfer_q <= text_scan_pkg::XFER_IDLE;
                end
                text_scan_pkg::XFER_FILL: begin
                    // Wraps past 7FF like the scanner does
                    fill_addr_q <= fill_addr_q + 11'h001;
                    if (fill_addr_q == fill_end_q) begin
                        transfer_done_flag <= 1'b1;
                        busy <= 1'b0;
                        xfer_q <= text_scan_pkg::XFER_IDLE;
                    end
                end
                default: begin
                    xfer_q <= text_scan_pkg::XFER_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== pkg/text_scan_pkg.sv
/*
 * Shared constants and state types of the character-cell display scanner.
 * Assumes a 10 MHz system clock and a synchronous glyph ROM outside.
 */
package text_scan_pkg;

    // Display memory geometry
    localparam int ADDR_W = 11;
    localparam int MEM_DEPTH = 2048;
    localparam logic [10:0] MEM_FIRST = 11'h000;
    localparam logic [10:0] MEM_LAST = 11'h7FF;

    // Screen geometry: 24 rows of 80 cells, 9 scan lines per row
    localparam logic [6:0] LAST_COL = 7'h4F;
    localparam logic [4:0] LAST_ROW = 5'h17;
    localparam logic [3:0] LAST_LINE = 4'h8;
    localparam logic [10:0] ROW_STEP = 11'h050;

    // Glyph ROM layout: sixteen bytes per code
    localparam int GLYPH_SHIFT = 4;
    localparam int ROM_ADDR_W = 11;
    localparam int CODE_W = 7;
    localparam int ATTR_BIT = 7;
    localparam int DOTS_W = 7;

    // Reset values of the latched screen origin and scan counters
    localparam logic [10:0] START_RESET = 11'h080;
    localparam logic [6:0] COL_RESET = 7'h00;
    localparam logic [3:0] LINE_RESET = 4'h0;
    localparam logic [4:0] ROW_RESET = 5'h00;

    // Cell pipeline: read memory, address ROM, wait ROM, push to buffer
    typedef enum logic [1:0] {
        SCAN_MEM,
        SCAN_ROM,
        SCAN_WAIT,
        SCAN_EMIT
    } scan_state_t;

    // Host transfer engine
    typedef enum logic [1:0] {
        XFER_IDLE,
        XFER_READ,
        XFER_LOAD,
        XFER_FILL
    } xfer_state_t;

endpackage

// ===== verification/text_scan_props.sv
/* Port checks of the display memory scanner.
   Assumes one clock domain; bound to the scanner top below. */
`timescale 1ns/1ps
module text_scan_props (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic ce, // Enable
    input wire logic [10:0] cursor_addr, // Fill start
    input wire logic [10:0] pointer_addr, // Fill end
    input wire logic cmd_write, // Write pulse
    input wire logic cmd_read, // Read pulse
    input wire logic cmd_fill, // Fill pulse
    input wire logic [10:0] rom_addr, // Glyph address
    input wire logic transfer_done_flag, // Done
    input wire logic busy, // Busy
    input wire logic pix_valid, // Valid
    input wire logic pix_ready, // Ready
    input wire logic [6:0] pix_dots, // Dots
    input wire logic pix_bright, // Bright
    input wire logic pix_line_start, // Line start
    input wire logic pix_frame_start // Frame start
);
    logic fill_q;
    logic [11:0] fill_n_q, fill_cnt_q;
    logic [6:0] col_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Busy cycles of the last fill, to compare with its span
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fill_q <= 1'b0;
            fill_n_q <= 12'h000;
            fill_cnt_q <= 12'h000;
        end else if (ce && !busy && (cmd_write || cmd_read || cmd_fill)) begin
            fill_q <= cmd_fill && !cmd_write && !cmd_read;
            fill_n_q <= {1'b0, pointer_addr - cursor_addr} + 12'h001;
            fill_cnt_q <= 12'h000;
        end else if (ce && busy) begin
            fill_cnt_q <= fill_cnt_q + 12'h001;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            col_q <= 7'h50;
        end else if (ce && pix_valid && pix_ready) begin
            col_q <= pix_line_start ? 7'h01 : col_q + 7'h01;
        end
    end
    sequence read_take;
        ce && !busy && cmd_read && !cmd_write;
    endsequence
    sequence read_wait;
        (busy && !transfer_done_flag) [*2];
    endsequence
    a_read_steps: assert property (
        read_take |=> read_wait ##1 (!busy && transfer_done_flag))
        else $error("read command timing wrong");
    a_write_quick: assert property (
        ce && !busy && cmd_write |=> !busy && transfer_done_flag)
        else $error("write command left the flag low");
    a_done_busy: assert property (
        transfer_done_flag == !busy)
        else $error("done flag and busy disagree");
    a_fill_length: assert property (
        $fell(busy) && fill_q |-> fill_cnt_q == fill_n_q)
        else $error("fill length wrong");
    a_line_range: assert property (
        rom_addr[3:0] <= 4'h8)
        else $error("unused glyph byte fetched");
    a_line_step: assert property (
        $changed(rom_addr) |-> rom_addr[3:0] == $past(rom_addr[3:0])
            || rom_addr[3:0] == $past(rom_addr[3:0]) + 4'h1
            || rom_addr[3:0] == 4'h0)
        else $error("glyph line index jumped");
    a_stall_hold: assert property (
        pix_valid && !pix_ready |=> pix_valid && $stable({pix_dots,
            pix_bright, pix_line_start, pix_frame_start}))
        else $error("slice changed while stalled");
    a_line_length: assert property (
        ce && pix_valid && pix_ready |-> pix_line_start == (col_q == 7'h50))
        else $error("scan line is not 80 cells");
    a_frame_line: assert property (
        pix_valid && pix_frame_start |-> pix_line_start)
        else $error("frame start off a line start");
endmodule
////////////////////////////////////////////////////////////////////////////
bind text_display_memory_scanner text_scan_props u_props (.clk(clk),
    .reset_n(reset_n), .ce(ce), .cursor_addr(cursor_addr),
    .pointer_addr(pointer_addr), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_fill(cmd_fill), .rom_addr(rom_addr),
    .transfer_done_flag(transfer_done_flag), .busy(busy),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_dots(pix_dots),
    .pix_bright(pix_bright), .pix_line_start(pix_line_start),
    .pix_frame_start(pix_frame_start));

// ===== verification/glyph_rom_model.sv
/* Glyph memory beside the scanner: sixteen bytes a code, nine used.
   Assumes the scanner uses each byte two edges after setting its address. */
`timescale 1ns/1ps
module glyph_rom_model (
    input wire logic clk, // Clock
    input wire logic [10:0] rom_addr, // Byte address
    output logic [7:0] rom_data // Glyph byte
);
    // One register stage: the byte stands one edge after the address
    // Bit 0 varies so a scanner that shows it is caught
    always_ff @(posedge clk) begin
        rom_data <= (rom_addr[3:0] > 4'h8) ? 8'h00
            : rom_addr[7:0] ^ rom_addr[10:3];
    end
endmodule

// ===== verification/text_display_memory_scanner_tb_top.sv
/* Bench: loads memory, fills and reads it, then checks one full frame
   and two partial ones. Assumes the glyph model and bound checker. */
`timescale 1ns/1ps
module text_display_memory_scanner_tb_top;
    logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, cursor_on = 1'b1;
    logic reverse_mode = 1'b0, cmd_write = 1'b0, cmd_read = 1'b0, ce_rnd = 1'b0;
    logic cmd_fill = 1'b0, pix_ready = 1'b0, hold_off = 1'b0, rd_go = 1'b0;
    logic [10:0] screen_start = 11'h080, cursor_addr = 11'h000;
    logic [10:0] pointer_addr = 11'h000, rom_addr;
    logic [7:0] write_buffer = 8'h00, rom_data, read_buffer;
    logic transfer_done_flag, busy, pix_valid, pix_bright;
    logic pix_line_start, pix_frame_start;
    logic [6:0] pix_dots;
    logic [7:0] mem [2048];
    logic [9:0] pix_q [$];
    logic [7:0] rd_q [$];
    logic [10:0] rd_list [7] = '{11'h7EF, 11'h7F0, 11'h7FF, 11'h000,
        11'h00F, 11'h010, 11'h400};
    int miscompares = 0, tests_run = 0, seed = 54, i;
    wire [9:0] got = {pix_frame_start, pix_line_start, pix_bright, pix_dots};
    text_display_memory_scanner uut (.clk(clk), .reset_n(reset_n),
        .ce(ce), .screen_start(screen_start), .cursor_addr(cursor_addr),
        .pointer_addr(pointer_addr), .write_buffer(write_buffer),
        .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_fill(cmd_fill),
        .reverse_mode(reverse_mode), .cursor_on(cursor_on),
        .rom_data(rom_data), .rom_addr(rom_addr), .read_buffer(read_buffer),
        .transfer_done_flag(transfer_done_flag), .busy(busy),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_dots(pix_dots),
        .pix_bright(pix_bright), .pix_line_start(pix_line_start),
        .pix_frame_start(pix_frame_start));
    glyph_rom_model rom (.clk(clk), .rom_addr(rom_addr), .rom_data(rom_data));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [9:0] exp,
                         input logic [9:0] seen);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic expect_slices(input logic [10:0] base, input int n,
                                 input logic rev);
        logic [10:0] a;
        logic [7:0] b, g;
        logic inv;
        for (int k = 0; k < n; k++) begin
            a = base + 11'((k / 720) * 80 + k % 80);
            b = mem[a];
            g = {b[3:0], 4'((k / 80) % 9)} ^ {b[6:0], 1'b0};
            inv = (cursor_on && a == cursor_addr) ^ (b[7] && rev);
            pix_q.push_back({k == 0, k % 80 == 0, b[7] && !rev,
                g[7:1] ^ {7{inv}}});
        end
    endtask
    task automatic command(input logic [2:0] k, input logic [10:0] p,
                           input logic [7:0] w);
        @(negedge clk);
        pointer_addr = p;
        write_buffer = w;
        {cmd_fill, cmd_read, cmd_write} = k;
        @(negedge clk);
        {cmd_fill, cmd_read, cmd_write} = 3'h0;
        for (int t = 0; t < 4000 && busy !== 1'b0; t++)
            @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
        if (pix_q.size() > 0 && pix_valid === 1'b1 && pix_ready === 1'b1
            && ce === 1'b1)
            check("slice", pix_q.pop_front(), got);
    always @(negedge clk) begin
        pix_ready = !hold_off && ($random(seed) % 8 != 0);
        ce = !ce_rnd || ($random(seed) % 8 != 0);
        if (rd_q.size() > 0 && busy === 1'b1)
            rd_go = 1'b1;
        else if (rd_go && transfer_done_flag === 1'b1) begin
            check("read_buffer", {2'h0, rd_q.pop_front()},
                {2'h0, read_buffer});
            rd_go = 1'b0;
        end
    end
    initial begin
        repeat (95000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        cmd_write = 1'b1;
        for (i = 0; i < 2048; i++) begin
            pointer_addr = 11'(i);
            write_buffer = 8'($random(seed));
            mem[i] = write_buffer;
            @(negedge clk);
        end
        cmd_write = 1'b0;
        cursor_addr = 11'h7F0;
        command(3'h4, 11'h00F, 8'hA5);
        cursor_addr = 11'h400;
        command(3'h4, 11'h400, 8'h3C);
        for (i = 0; i < 32; i++)
            mem[11'(12'h7F0 + 12'(i))] = 8'hA5;
        mem[11'h400] = 8'h3C;
        foreach (rd_list[j]) begin
            rd_q.push_back(mem[rd_list[j]]);
            command(3'h2, rd_list[j], 8'h00);
        end
        // Memory survives reset, so a reset now starts a known frame
        @(negedge clk);
        reset_n = 1'b0;
        cursor_addr = 11'h010;
        expect_slices(11'h080, 17280, 1'b0);
        expect_slices(11'h7E0, 800, 1'b0);
        @(negedge clk);
        reset_n = 1'b1;
        repeat (3000) @(negedge clk);
        hold_off = 1'b1;
        repeat (40) @(negedge clk);
        hold_off = 1'b0;
        screen_start = 11'h7E0;
        for (i = 0; i < 90000 && pix_q.size() > 0; i++)
            @(negedge clk);
        check("slices left", 10'h000, 10'(pix_q.size() != 0));
        pix_q.delete();
        reset_n = 1'b0;
        reverse_mode = 1'b1;
        ce_rnd = 1'b1;
        cursor_on = 1'b0;
        cursor_addr = 11'h085;
        expect_slices(11'h080, 800, 1'b1);
        @(negedge clk);
        reset_n = 1'b1;
        for (i = 0; i < 5000 && pix_q.size() > 0; i++)
            @(negedge clk);
        check("queues left", 10'h000,
            10'(pix_q.size() + rd_q.size() != 0));
        conclude();
    end
endmodule
